// file: common/dirp_map.vh
// Register indices, field positions, reset values and limits of the routing path.
`ifndef DIRP_MAP_VH
`define DIRP_MAP_VH

// Register indices; the byte address is four times the index.
`define DIRP_IDX_POWER 8'h12
`define DIRP_IDX_IFCTL 8'h18
`define DIRP_IDX_DRC 8'h28
`define DIRP_IDX_STATUS 8'h29
`define DIRP_IDX_EQ 8'h86
`define DIRP_IDX_GAIN_FIRST 8'h87
`define DIRP_IDX_GAIN_LAST 8'h8b
`define DIRP_IDX_COEF_FIRST 8'h8c
`define DIRP_IDX_COEF_LAST 8'h9d

// Converter power enables.
`define DIRP_BIT_LEFT_ON 3
`define DIRP_BIT_RIGHT_ON 2

// Playback interface control.
`define DIRP_BIT_LEFT_INV 12
`define DIRP_BIT_RIGHT_INV 11
`define DIRP_BOOST_HI 10
`define DIRP_BOOST_LO 9
`define DIRP_BIT_LEFT_SRC 5
`define DIRP_BIT_RIGHT_SRC 4
`define DIRP_IFCTL_RESET 16'h0010
`define DIRP_IFCTL_MASK 16'h1e30
`define DIRP_POWER_MASK 16'h000c

// Equaliser control: enable and programmable-coefficient mode.
`define DIRP_BIT_EQ_ON 0
`define DIRP_BIT_EQ_PROG 1
`define DIRP_GAIN_RESET 5'h0c
`define DIRP_GAIN_MAX 5'h18
`define DIRP_COEF_COUNT 18

// Dynamic range control enable.
`define DIRP_BIT_DRC_ON 0

// Sample limits and the compression knee (about -12 dBFS).
`define DIRP_SAMPLE_MAX 24'h7fffff
`define DIRP_SAMPLE_MIN 24'h800000
`define DIRP_DRC_KNEE 25'h0200000
`define DIRP_GAIN_FRAC 12

`endif

// file: core/dirp_path.v
// Playback input routing, gain, equaliser, compression and interpolation.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "dirp_map.vh"

// Sample FIFO between the interface and the processing stage.
module dirp_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [WIDTH-1:0] i_data,
  input wire i_valid,
  output wire o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire o_valid,
  input wire i_ready,
  output wire [AW:0] o_count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q, rd_q;
  wire push, pop;
  // Pointers carry one extra bit so full and empty differ.
  assign o_count = wr_q - rd_q;
  assign o_ready = (o_count != DEPTH[AW:0]);
  assign o_valid = (wr_q != rd_q);
  assign o_data = mem[rd_q[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  // Storage and pointer update.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_q[AW-1:0]] <= i_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// One converter channel: invert, boost, equaliser gain, compression, enable.
module dirp_channel (
  input wire [23:0] i_sample,
  input wire i_invert,
  input wire [1:0] i_boost,
  input wire i_eq_on,
  input wire [15:0] i_eq_gain,
  input wire i_drc_on,
  input wire i_enable,
  output reg [23:0] o_sample
);
  localparam signed [30:0] BMAX = 31'h007fffff;
  localparam signed [30:0] BMIN = 31'h7f800000;
  localparam signed [28:0] EMAX = 29'h007fffff;
  localparam signed [28:0] EMIN = 29'h1f800000;
  localparam signed [24:0] KNEE = `DIRP_DRC_KNEE;
  reg signed [23:0] inv, bsat, esat;
  reg signed [30:0] bst;
  reg signed [40:0] prod;
  reg signed [28:0] eqs;
  reg signed [24:0] ext, cmp;
  // The chain is combinational; the caller registers the result.
  always @* begin
    inv = i_sample;
    if (i_invert) begin
      if (i_sample == `DIRP_SAMPLE_MIN) begin
        inv = `DIRP_SAMPLE_MAX;
      end else begin
        inv = -i_sample;
      end
    end
    // Each boost step doubles the sample, close to 6 dB.
    bst = {{7{inv[23]}}, inv} <<< i_boost;
    if (bst > BMAX) begin
      bsat = `DIRP_SAMPLE_MAX;
    end else if (bst < BMIN) begin
      bsat = `DIRP_SAMPLE_MIN;
    end else begin
      bsat = bst[23:0];
    end
    prod = bsat * $signed({1'b0, i_eq_gain});
    eqs = prod[40:`DIRP_GAIN_FRAC];
    if (!i_eq_on) begin
      esat = bsat;
    end else if (eqs > EMAX) begin
      esat = `DIRP_SAMPLE_MAX;
    end else if (eqs < EMIN) begin
      esat = `DIRP_SAMPLE_MIN;
    end else begin
      esat = eqs[23:0];
    end
    // Two-to-one compression above the knee keeps loud peaks in range.
    ext = {esat[23], esat};
    cmp = ext;
    if (i_drc_on && (ext > KNEE)) begin
      cmp = KNEE + ((ext - KNEE) >>> 1);
    end else if (i_drc_on && (ext < -KNEE)) begin
      cmp = ((ext + KNEE) >>> 1) - KNEE;
    end
    o_sample = i_enable ? cmp[23:0] : 24'h000000;
  end
endmodule

// Top level: register file, FIFO, routing, channels and interpolator.
module dirp_path #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [9:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire [23:0] i_left_sample,
  input wire [23:0] i_right_sample,
  input wire i_in_valid,
  output wire o_in_ready,
  output reg [23:0] o_left_out,
  output reg [23:0] o_right_out,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg o_left_active,
  output reg o_right_active
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_MID = 3'h2;
  localparam [2:0] ST_FULL = 3'h4;
  reg [15:0] power_q, ifctl_q;
  reg drc_on_q, eq_on_q, eq_prog_q;
  reg [4:0] gain_q [0:4];
  reg [15:0] coef_q [0:`DIRP_COEF_COUNT-1];
  reg [31:0] rdata_d;
  reg [2:0] st_q;
  reg [23:0] cur_l_q, cur_r_q, prev_l_q, prev_r_q;
  reg [15:0] eq_gain;
  integer i;
  wire [7:0] idx, gidx, cidx;
  wire aligned, wr_ok, rd_ok, fifo_valid, fifo_pop, out_free;
  wire [47:0] fifo_data;
  wire [FIFO_AW:0] fifo_count;
  wire [23:0] route_l, route_r, proc_l, proc_r;
  wire [24:0] sum_l, sum_r;

  // Misaligned addresses are treated as unmapped.
  assign idx = i_addr[9:2];
  assign aligned = (i_addr[1:0] == 2'h0);
  assign wr_ok = i_wr && aligned;
  assign rd_ok = i_rd && aligned;
  assign gidx = idx - `DIRP_IDX_GAIN_FIRST;
  assign cidx = idx - `DIRP_IDX_COEF_FIRST;
  // Register writes; unmapped indices and reserved bits are dropped.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      power_q <= 16'h0000;
      ifctl_q <= `DIRP_IFCTL_RESET;
      drc_on_q <= 1'b0;
      eq_on_q <= 1'b0;
      eq_prog_q <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        gain_q[i] <= `DIRP_GAIN_RESET;
      end
      for (i = 0; i < `DIRP_COEF_COUNT; i = i + 1) begin
        coef_q[i] <= 16'h0000;
      end
    end else if (wr_ok) begin
      if (idx == `DIRP_IDX_POWER) begin
        power_q <= i_wdata[15:0] & `DIRP_POWER_MASK;
      end
      if (idx == `DIRP_IDX_IFCTL) begin
        ifctl_q <= i_wdata[15:0] & `DIRP_IFCTL_MASK;
      end
      if (idx == `DIRP_IDX_DRC) begin
        drc_on_q <= i_wdata[`DIRP_BIT_DRC_ON];
      end
      if (idx == `DIRP_IDX_EQ) begin
        eq_on_q <= i_wdata[`DIRP_BIT_EQ_ON];
        eq_prog_q <= i_wdata[`DIRP_BIT_EQ_PROG];
      end
      if ((idx >= `DIRP_IDX_GAIN_FIRST) && (idx <= `DIRP_IDX_GAIN_LAST)) begin
        gain_q[gidx[2:0]] <= i_wdata[4:0];
      end
      if ((idx >= `DIRP_IDX_COEF_FIRST) && (idx <= `DIRP_IDX_COEF_LAST)) begin
        coef_q[cidx[4:0]] <= i_wdata[15:0];
      end
    end
  end
  // Read mux; the status word shows the FIFO fill level and stage state.
  always @* begin
    rdata_d = 32'h00000000;
    if (rd_ok) begin
      if (idx == `DIRP_IDX_POWER) begin
        rdata_d = {16'h0000, power_q};
      end else if (idx == `DIRP_IDX_IFCTL) begin
        rdata_d = {16'h0000, ifctl_q};
      end else if (idx == `DIRP_IDX_DRC) begin
        rdata_d = {31'h00000000, drc_on_q};
      end else if (idx == `DIRP_IDX_STATUS) begin
        rdata_d = {21'h000000, st_q, 3'h0, fifo_count};
      end else if (idx == `DIRP_IDX_EQ) begin
        rdata_d = {30'h00000000, eq_prog_q, eq_on_q};
      end else if ((idx >= `DIRP_IDX_GAIN_FIRST) &&
                   (idx <= `DIRP_IDX_GAIN_LAST)) begin
        rdata_d = {27'h0000000, gain_q[gidx[2:0]]};
      end else if ((idx >= `DIRP_IDX_COEF_FIRST) &&
                   (idx <= `DIRP_IDX_COEF_LAST)) begin
        rdata_d = {16'h0000, coef_q[cidx[4:0]]};
      end
    end
  end
  // Read data stand only in the cycle after the read strobe; the converter
  // enables are shown to the analogue side one cycle after they are written.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 32'h00000000;
      o_left_active <= 1'b0;
      o_right_active <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_left_active <= power_q[`DIRP_BIT_LEFT_ON];
      o_right_active <= power_q[`DIRP_BIT_RIGHT_ON];
    end
  end

  // Band gains in Q12 for codes 0 to 24, code 0 in the lowest word.
  localparam [399:0] GAIN_TAB = {
    16'h3fb2, 16'h38c5, 16'h3299, 16'h2d18, 16'h2831,
    16'h23d2, 16'h1fed, 16'h1c74, 16'h195c, 16'h169a,
    16'h1425, 16'h11f4, 16'h1000, 16'h0e43, 16'h0cb6,
    16'h0b53, 16'h0a18, 16'h08ff, 16'h0805, 16'h0726,
    16'h065f, 16'h05ad, 16'h050f, 16'h0485, 16'h0407
  };

  // Broadband equaliser gain from the centre band, or coef_q[0] in programmable mode;
  // filters are left out to keep the stage small. Reserved codes act as +12 dB.
  always @* begin
    if (eq_prog_q) begin
      eq_gain = coef_q[0];
    end else if (gain_q[2] > `DIRP_GAIN_MAX) begin
      eq_gain = GAIN_TAB[399:384];
    end else begin
      eq_gain = GAIN_TAB[{gain_q[2], 4'h0} +: 16];
    end
  end
  dirp_fifo #(
    .WIDTH(48),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_data({i_left_sample, i_right_sample}),
    .i_valid(i_in_valid),
    .o_ready(o_in_ready),
    .o_data(fifo_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_count(fifo_count)
  );
  // Source selection allows either channel or a mono feed on both.
  assign route_l = ifctl_q[`DIRP_BIT_LEFT_SRC] ? fifo_data[23:0] :
                   fifo_data[47:24];
  assign route_r = ifctl_q[`DIRP_BIT_RIGHT_SRC] ? fifo_data[23:0] :
                   fifo_data[47:24];

  dirp_channel u_left (
    .i_sample(route_l),
    .i_invert(ifctl_q[`DIRP_BIT_LEFT_INV]),
    .i_boost(ifctl_q[`DIRP_BOOST_HI:`DIRP_BOOST_LO]),
    .i_eq_on(eq_on_q),
    .i_eq_gain(eq_gain),
    .i_drc_on(drc_on_q),
    .i_enable(power_q[`DIRP_BIT_LEFT_ON]),
    .o_sample(proc_l)
  );
  dirp_channel u_right (
    .i_sample(route_r),
    .i_invert(ifctl_q[`DIRP_BIT_RIGHT_INV]),
    .i_boost(ifctl_q[`DIRP_BOOST_HI:`DIRP_BOOST_LO]),
    .i_eq_on(eq_on_q),
    .i_eq_gain(eq_gain),
    .i_drc_on(drc_on_q),
    .i_enable(power_q[`DIRP_BIT_RIGHT_ON]),
    .o_sample(proc_r)
  );
  // The interpolator emits a midpoint, then the sample itself.
  assign fifo_pop = fifo_valid && (st_q == ST_IDLE);
  assign out_free = !o_out_valid || i_out_ready;
  assign sum_l = {prev_l_q[23], prev_l_q} + {cur_l_q[23], cur_l_q};
  assign sum_r = {prev_r_q[23], prev_r_q} + {cur_r_q[23], cur_r_q};
  // Twofold interpolation at full 24-bit precision.
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      st_q <= ST_IDLE;
      cur_l_q <= 24'h000000;
      cur_r_q <= 24'h000000;
      prev_l_q <= 24'h000000;
      prev_r_q <= 24'h000000;
      o_left_out <= 24'h000000;
      o_right_out <= 24'h000000;
      o_out_valid <= 1'b0;
    end else begin
      if (out_free) begin
        o_out_valid <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (fifo_pop) begin
            cur_l_q <= proc_l;
            cur_r_q <= proc_r;
            st_q <= ST_MID;
          end
        end
        ST_MID: begin
          if (out_free) begin
            o_left_out <= sum_l[24:1];
            o_right_out <= sum_r[24:1];
            o_out_valid <= 1'b1;
            st_q <= ST_FULL;
          end
        end
        ST_FULL: begin
          if (out_free) begin
            o_left_out <= cur_l_q;
            o_right_out <= cur_r_q;
            o_out_valid <= 1'b1;
            prev_l_q <= cur_l_q;
            prev_r_q <= cur_r_q;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: verification/dirp_path_assertions.sv
// Port-level concurrent checks for the playback routing path.
`timescale 1ns/100ps
`include "dirp_map.vh"
module dirp_path_assertions #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [9:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [23:0] o_left_out,
  input wire [23:0] o_right_out,
  input wire o_out_valid,
  input wire i_out_ready,
  input wire o_left_active,
  input wire o_right_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // Read data stands for one cycle only, so it cannot mask a later read.
  a_rdata_one_cycle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data seen without a read");
  a_unmapped_zero: assert property (i_rd && i_addr[1:0] != 2'b00
    |=> o_rdata == 32'h0) else $error("misaligned read not zero");
  a_ifctl_readback: assert property ((i_wr && i_addr == 10'h060) ##1
    (i_rd && i_addr == 10'h060) |=> o_rdata == {16'h0,
    $past(i_wdata[15:0], 2) & `DIRP_IFCTL_MASK})
    else $error("control readback wrong");
  a_power_readback: assert property ((i_wr && i_addr == 10'h048) ##1
    (i_rd && i_addr == 10'h048) |=> o_rdata == {16'h0,
    $past(i_wdata[15:0], 2) & `DIRP_POWER_MASK})
    else $error("enable readback wrong");
  a_left_on_follows: assert property ((i_wr && i_addr == 10'h048) ##1
    (!i_wr) [*2] |-> o_left_active == $past(i_wdata[3], 2))
    else $error("left active does not follow enable");
  a_right_on_follows: assert property ((i_wr && i_addr == 10'h048) ##1
    (!i_wr) [*2] |-> o_right_active == $past(i_wdata[2], 2))
    else $error("right active does not follow enable");
  a_out_pair_holds: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_left_out) && $stable(o_right_out))
    else $error("output pair changed while stalled");
  a_reset_quiet: assert property ($fell(i_reset) |-> !o_out_valid &&
    !o_left_active && !o_right_active)
    else $error("outputs not quiet after reset");
endmodule

bind dirp_path dirp_path_assertions #(.FIFO_DEPTH(FIFO_DEPTH),
  .FIFO_AW(FIFO_AW)) u_dirp_path_assertions (.i_core_clk(i_core_clk),
  .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_left_out(o_left_out),
  .o_right_out(o_right_out), .o_out_valid(o_out_valid),
  .i_out_ready(i_out_ready), .o_left_active(o_left_active),
  .o_right_active(o_right_active));

// file: verification/dirp_src_model.sv
// Model of the audio interface that delivers playback sample pairs.
`timescale 1ns/100ps
module dirp_src_model (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ready,
  output logic [23:0] o_left,
  output logic [23:0] o_right,
  output logic o_valid
);
  logic [47:0] pend_q[$];

  // Queue a pair; callers may drive boosted input past full scale to test saturation.
  function automatic void put(input logic [47:0] pair);
    pend_q.push_back(pair);
  endfunction

  initial begin
    o_valid = 1'b0;
    o_left = 24'h0;
    o_right = 24'h0;
  end

  // A pair holds until taken; idle lines toggle so stale data never match.
  always @(posedge i_core_clk) begin
    if (o_valid && i_ready && !i_reset)
      pend_q.delete(0);
    if (i_reset || pend_q.size() == 0) begin
      o_valid <= 1'b0;
      o_left <= ~o_left;
      o_right <= ~o_right;
    end else begin
      o_valid <= 1'b1;
      {o_left, o_right} <= pend_q[0];
    end
  end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the playback routing path.
`timescale 1ns/100ps
module testbench;
  logic i_core_clk, i_reset, i_wr, i_rd, i_in_valid, i_out_ready;
  logic o_in_ready, o_out_valid, o_left_active, o_right_active;
  logic [9:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [23:0] i_left_sample, i_right_sample, o_left_out, o_right_out;
  logic [23:0] pl, pr;
  logic [47:0] out_q[$];
  int error_cnt, compares;

  dirp_path #(.FIFO_DEPTH(16), .FIFO_AW(4)) u_dirp_path (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_left_sample(i_left_sample), .i_right_sample(i_right_sample),
    .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
    .o_left_out(o_left_out), .o_right_out(o_right_out),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
    .o_left_active(o_left_active), .o_right_active(o_right_active));
  dirp_src_model u_dirp_src_model (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_ready(o_in_ready), .o_left(i_left_sample),
    .o_right(i_right_sample), .o_valid(i_in_valid));

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // Every accepted output pair is logged for the scenario to judge.
  always @(posedge i_core_clk) begin
    if (!i_reset && o_out_valid && i_out_ready)
      out_q.push_back({o_left_out, o_right_out});
  end

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffffffff);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask

  // Write followed at once by a read of the same place.
  task automatic wrrd(input logic [9:0] a, input logic [31:0] d, exp);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  // One pair in, midpoint then sample out; odd midpoint sums are skipped.
  task automatic xfer(input logic [23:0] l, r, el, er);
    logic signed [24:0] sl, sr;
    int n;
    @(negedge i_core_clk);
    u_dirp_src_model.put({l, r});
    n = 0;
    while (out_q.size() < 2 && n < 60) begin
      @(posedge i_core_clk);
      n++;
    end
    #1 chk(out_q.size(), 2);
    if (out_q.size() == 2) begin
      sl = $signed({pl[23], pl}) + $signed({el[23], el});
      sr = $signed({pr[23], pr}) + $signed({er[23], er});
      if (!sl[0]) chk(out_q[0][47:24], sl[24:1]);
      if (!sr[0]) chk(out_q[0][23:0], sr[24:1]);
      chk(out_q[1], {el, er});
    end
    out_q = {};
    pl = el;
    pr = er;
  endtask

  task automatic t_regs();
    rd(10'h048, 32'h0);
    rd(10'h060, 32'h10);
    rd(10'h224, 32'h0c);
    rd(10'h0a4, 32'h100, 32'h71f);
    wrrd(10'h062, 32'hffff, 32'h0);
    rd(10'h060, 32'h10);
    rd(10'h3fc, 32'h0);
  endtask

  task automatic t_route();
    for (int s = 0; s < 4; s++) begin
      wrrd(10'h060, s << 4, s << 4);
      xfer(24'h1000, 24'h2000, s[1] ? 24'h2000 : 24'h1000,
           s[0] ? 24'h2000 : 24'h1000);
    end
  endtask

  task automatic t_gain();
    wrrd(10'h060, 32'h1810, 32'h1810);
    xfer(24'h1000, 24'h2000, 24'hfff000, 24'hffe000);
    xfer(24'h800000, 24'h7fffff, 24'h7fffff, 24'h800001);
    for (int b = 0; b < 4; b++) begin
      wrrd(10'h060, 32'h10 | (b << 9), 32'h10 | (b << 9));
      xfer(24'h1000, 24'hfff000, 24'h1000 << b,
           24'h0 - (24'h1000 << b));
    end
    xfer(24'h200000, 24'he00000, 24'h7fffff, 24'h800000);
    wrrd(10'h060, 32'h10, 32'h10);
  endtask

  task automatic t_enable();
    wrrd(10'h048, 32'h8, 32'h8);
    repeat (3) @(posedge i_core_clk);
    chk(o_left_active, 1'b1);
    chk(o_right_active, 1'b0);
    xfer(24'h2000, 24'h2000, 24'h2000, 24'h0);
    wrrd(10'h048, 32'h4, 32'h4);
    xfer(24'h2000, 24'h2000, 24'h0, 24'h2000);
    wrrd(10'h048, 32'hc, 32'hc);
  endtask

  task automatic t_eq_drc();
    wrrd(10'h230, 32'h800, 32'h800);
    wrrd(10'h274, 32'habcd, 32'habcd);
    wrrd(10'h218, 32'h3, 32'h3);
    xfer(24'h2000, 24'h4000, 24'h1000, 24'h2000);
    wrrd(10'h224, 32'h1f, 32'h1f);
    wrrd(10'h224, 32'h0c, 32'h0c);
    wrrd(10'h218, 32'h1, 32'h1);
    xfer(24'h2000, 24'h4000, 24'h2000, 24'h4000);
    wrrd(10'h224, 32'h18, 32'h18);
    xfer(24'h2000, 24'h4000, 24'h7f64, 24'hfec8);
    wrrd(10'h224, 32'h0c, 32'h0c);
    wrrd(10'h218, 32'h0, 32'h0);
    wrrd(10'h0a0, 32'h1, 32'h1);
    xfer(24'h100000, 24'h400000, 24'h100000, 24'h300000);
    xfer(24'hf00000, 24'hc00000, 24'hf00000, 24'hd00000);
    wrrd(10'h0a0, 32'h0, 32'h0);
  endtask

  // Fill until the buffer refuses, then drain while the consumer is ready every other cycle.
  task automatic t_fifo();
    int n;
    @(posedge i_core_clk);
    i_out_ready <= 1'b0;
    @(negedge i_core_clk);
    for (int k = 1; k <= 20; k++)
      u_dirp_src_model.put({24'(k * 256), 24'(k * 512)});
    repeat (60) @(posedge i_core_clk);
    #1 chk(o_in_ready, 1'b0);
    rd(10'h0a4, 32'h410, 32'h71f);
    n = 0;
    while (out_q.size() < 40 && n < 400) begin
      @(posedge i_core_clk);
      i_out_ready <= ~i_out_ready;
      n++;
    end
    @(posedge i_core_clk);
    i_out_ready <= 1'b1;
    chk(out_q.size(), 40);
    for (int k = 1; k <= 20 && k * 2 <= out_q.size(); k++)
      chk(out_q[2 * k - 1], {24'(k * 256), 24'(k * 512)});
    out_q = {};
    pl = 24'h1400;
    pr = 24'h2800;
    rd(10'h0a4, 32'h100, 32'h71f);
  endtask

  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 10'h0;
    i_wdata = 32'h0;
    i_out_ready = 1'b1;
    pl = 24'h0;
    pr = 24'h0;
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    t_regs();
    wrrd(10'h048, 32'hc, 32'hc);
    t_route();
    t_gain();
    t_enable();
    t_eq_drc();
    t_fifo();
    end_of_test();
  end

  // A hang is cut short well past the expected run length.
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule
